// ---- logic/pmw_defs.vh ----
`ifndef PMW_DEFS_VH
`define PMW_DEFS_VH
// Register byte addresses on APB
`define PMW_ADDR_SYSCLK      12'h000
`define PMW_ADDR_HRC         12'h004
`define PMW_ADDR_HXTAL       12'h008
`define PMW_ADDR_LXTAL       12'h00c
`define PMW_ADDR_WDT         12'h010
`define PMW_ADDR_PAWAKE      12'h014
`define PMW_ADDR_STATUS      12'h018
`define PMW_ADDR_MODE        12'h01c
// System clock control fields
`define PMW_CKS_HI           7
`define PMW_CKS_LO           5
`define PMW_FHS_BIT          3
`define PMW_FSS_BIT          2
`define PMW_FAST_OSC_IDLE_ENABLE_BIT       1
`define PMW_SLOW_OSC_IDLE_ENABLE_BIT       0
`define PMW_CKS_SLOW         3'h7
// Oscillator control fields
`define PMW_EN_BIT           0
`define PMW_STABLE_BIT       1
// Reset values
`define PMW_SYSCLK_RST       8'h00
`define PMW_HRC_RST          8'h01
`define PMW_HXTAL_RST        8'h00
`define PMW_LXTAL_RST        8'h00
`define PMW_WDT_RST          8'h53
`define PMW_WDT_EN_HI        7
`define PMW_WDT_EN_LO        3
`define PMW_WDT_ENABLE       5'h0a
// Status fields
`define PMW_ST_PDF_BIT       0
`define PMW_ST_TO_BIT        1
// Mode codes
`define PMW_MODE_FAST        3'h0
`define PMW_MODE_SLOW        3'h1
`define PMW_MODE_SLEEP       3'h2
`define PMW_MODE_IDLE_SLOW_ONLY       3'h3
`define PMW_MODE_IDLE_BOTH_CLOCKS       3'h4
`define PMW_MODE_IDLE_FAST_ONLY       3'h5
`define PMW_MODE_WAKE        3'h6
`endif

// ---- logic/pmw_power_mode_wake_controller.v ----
// Function
// - Setting low crystal enable clears its stable flag, set again once stable.
// - Low crystal control bit0 is enable, bit1 read-only stable flag.
// - Low crystal control bits 7..2 read zero.
// - Clock select 111 moves system clock to slow clock.
// - Slow clock from crystal or RC by select; switch waits for stable.
// - Clock select 000..110 divides fast clock by 1..64.
// - Fast clock not used after slow mode until its oscillator is stable.
// - Halt with both idle enables 0 enters sleep; only watchdog runs.
// - Halt with fast 0, slow 1 enters slow-only idle.
// - Halt with both idle enables 1 enters both-clocks idle.
// - Halt with fast 1, slow 0 enters fast-only idle.
// - Sleep and idle keep memory, registers and ports unchanged.
// - Halt entry sets power-down flag and clears timeout flag.
// - Halt entry clears watchdog counter; it keeps counting if enabled.
// - Wake on port A edge, external reset, interrupt or watchdog overflow.
// - Power-down flag cleared only by power-up or clear-watchdog instruction.
// - Watchdog overflow while halted sets timeout, resets only PC and SP.
// - Each port A pin has a wake enable; falling edge resumes after halt.
// - Disabled or stack-full waking interrupt resumes after halt, serviced later.
// - Enabled interrupt with stack room gets normal response on wake.
// - Interrupt flagged before halt cannot wake the device.
// - Clock select sits in bits 7..5 of system clock control.
// - Slow source select 0 picks low RC, 1 picks low crystal.
// - Low RC runs whenever watchdog is enabled.
//
// The implementer's own choices: register access over APB and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
`include "pmw_defs.vh"
module pmw_power_mode_wake_controller #(
    parameter PORT_WIDTH = 8,
    parameter IRQ_WIDTH  = 8
) (
    input  wire                  clk,
    input  wire                  reset,
    input  wire                  psel,
    input  wire                  penable,
    input  wire                  pwrite,
    input  wire [11:0]           paddr,
    input  wire [31:0]           pwdata,
    output wire                  pready,
    output reg  [31:0]           prdata,
    output wire                  pslverr,
    input  wire                  haltExec,
    input  wire                  clearWdtExec,
    input  wire                  extResetReq,
    input  wire [IRQ_WIDTH-1:0]  irqFlag,
    input  wire [IRQ_WIDTH-1:0]  irqEnable,
    input  wire                  stackFull,
    input  wire [PORT_WIDTH-1:0] portAPins,
    input  wire                  highRcReady,
    input  wire                  highCrystalReady,
    input  wire                  lowCrystalReady,
    input  wire                  lowRcReady,
    input  wire                  wdtOverflow,
    output reg                   highRcOn,
    output reg                   highCrystalOn,
    output reg                   lowCrystalOn,
    output reg                   lowRcOn,
    output reg                   fastClockEnable,
    output reg                   slowClockEnable,
    output reg                   sysClockIsSlow,
    output reg  [2:0]            fastDivideSel,
    output reg                   slowFromCrystal,
    output reg                   cpuRun,
    output reg                   wdtClear,
    output reg                   wdtRun,
    output reg                   pcSpReset,
    output reg                   irqServiceNow,
    output reg  [2:0]            powerMode
);
    // Control registers
    reg  [7:0] system_clock_ctrl_reg;
    reg  [7:0] high_rc_ctrl_reg;
    reg  [7:0] high_crystal_ctrl_reg;
    reg  [7:0] low_crystal_ctrl_reg;
    reg  [7:0] wdt_ctrl_reg;
    reg  [PORT_WIDTH-1:0] porta_wake_enable;
    // Status and oscillator stable flags
    reg        power_down_flag;
    reg        wdt_timeout_flag;
    reg        high_rc_stable_flag;
    reg        high_crystal_stable_flag;
    reg        low_crystal_stable_flag;
    reg        slowActive;
    reg  [2:0] state;
    // Interrupt bits still allowed to wake; flags already set at halt are dropped
    reg  [IRQ_WIDTH-1:0] irqArmed;

    // Two-stage synchronisers for pins and oscillator readiness
    // A third port stage keeps the last synced level for falling-edge detection
    reg  [PORT_WIDTH-1:0] portMeta;
    reg  [PORT_WIDTH-1:0] portSync;
    reg  [PORT_WIDTH-1:0] portPrev;
    reg  [4:0] rdyMeta;
    reg  [4:0] rdySync;
    always @(posedge clk) begin
        portMeta <= portAPins;
        portSync <= portMeta;
        portPrev <= portSync;
        rdyMeta  <= {wdtOverflow, lowRcReady, lowCrystalReady, highCrystalReady, highRcReady};
        rdySync  <= rdyMeta;
    end

    // High RC and crystal readiness counts only while software has the oscillator enabled; low RC readiness is not gated
    wire hrcRdy  = rdySync[0] & high_rc_ctrl_reg[`PMW_EN_BIT];
    wire hxtRdy  = rdySync[1] & high_crystal_ctrl_reg[`PMW_EN_BIT];
    wire lxtRdy  = rdySync[2] & low_crystal_ctrl_reg[`PMW_EN_BIT];
    wire lircRdy = rdySync[3];
    wire wdtOvf  = rdySync[4];

    // Field decode of the watchdog and system clock control registers
    wire wdtEnabled = (wdt_ctrl_reg[`PMW_WDT_EN_HI:`PMW_WDT_EN_LO] == `PMW_WDT_ENABLE);
    wire [2:0] cks = system_clock_ctrl_reg[`PMW_CKS_HI:`PMW_CKS_LO];
    wire slow_source_select    = system_clock_ctrl_reg[`PMW_FSS_BIT];
    wire fast_source_select    = system_clock_ctrl_reg[`PMW_FHS_BIT];
    wire fhIdle = system_clock_ctrl_reg[`PMW_FAST_OSC_IDLE_ENABLE_BIT];
    wire fsIdle = system_clock_ctrl_reg[`PMW_SLOW_OSC_IDLE_ENABLE_BIT];

    // Run-mode decode, shared by the halt gate and the CPU enable
    function runMode;
        input [2:0] m;
        begin
            runMode = (m == `PMW_MODE_FAST) || (m == `PMW_MODE_SLOW);
        end
    endfunction

    // Stable flag of the chosen slow or fast source
    wire slowRdy = slow_source_select ? low_crystal_stable_flag : lircRdy;
    wire fastRdy = fast_source_select ? high_crystal_stable_flag : high_rc_stable_flag;
    // WAKE is neither halted nor running: registers may change, the CPU still waits
    wire halted  = !runMode(state) && (state != `PMW_MODE_WAKE);

    // Wake sources; only fresh interrupt requests count
    wire portWake = |(portPrev & ~portSync & porta_wake_enable);
    wire [IRQ_WIDTH-1:0] irqFresh = irqFlag & irqArmed;
    wire irqWake  = |irqFresh;
    wire anyWake  = portWake | irqWake | extResetReq | (wdtOvf & wdtRun);

    // APB: zero wait state, never errors
    // Every request is answered in its first access cycle
    wire apbWr = psel & penable & pwrite;
    assign pready  = 1'b1;
    assign pslverr = 1'b0;

    // Read mux
    function [7:0] readReg;
        input [11:0] a;
        begin
            // Unimplemented bits and unknown words read as zero
            case (a)
                `PMW_ADDR_SYSCLK: readReg = system_clock_ctrl_reg & 8'hef;
                `PMW_ADDR_HRC:    readReg = {4'h0, high_rc_ctrl_reg[3:2],
                                             high_rc_stable_flag, high_rc_ctrl_reg[0]};
                `PMW_ADDR_HXTAL:  readReg = {5'h00, high_crystal_ctrl_reg[2],
                                             high_crystal_stable_flag, high_crystal_ctrl_reg[0]};
                `PMW_ADDR_LXTAL:  readReg = {6'h00, low_crystal_stable_flag,
                                             low_crystal_ctrl_reg[0]};
                `PMW_ADDR_WDT:    readReg = wdt_ctrl_reg;
                `PMW_ADDR_PAWAKE: readReg = porta_wake_enable;
                `PMW_ADDR_STATUS: readReg = {6'h00, wdt_timeout_flag, power_down_flag};
                `PMW_ADDR_MODE:   readReg = {4'h0, slowActive, state};
                default:          readReg = 8'h00;
            endcase
        end
    endfunction

    // Read word loads each cycle from the setup address, so it stands in the access phase
    always @(posedge clk) begin
        if (reset) begin
            prdata <= 32'h00000000;
        end else begin
            prdata <= {24'h000000, readReg(paddr)};
        end
    end

    // Register writes; halted CPU cannot write, so state is kept
    // Missing bits are masked on write so every read of them returns zero
    always @(posedge clk) begin
        if (reset) begin
            system_clock_ctrl_reg <= `PMW_SYSCLK_RST;
            high_rc_ctrl_reg      <= `PMW_HRC_RST;
            high_crystal_ctrl_reg <= `PMW_HXTAL_RST;
            low_crystal_ctrl_reg  <= `PMW_LXTAL_RST;
            wdt_ctrl_reg          <= `PMW_WDT_RST;
            porta_wake_enable     <= {PORT_WIDTH{1'b0}};
        end else if (apbWr && !halted) begin
            case (paddr)
                `PMW_ADDR_SYSCLK: system_clock_ctrl_reg <= pwdata[7:0] & 8'hef;
                `PMW_ADDR_HRC:    high_rc_ctrl_reg      <= pwdata[7:0] & 8'h0d;
                `PMW_ADDR_HXTAL:  high_crystal_ctrl_reg <= pwdata[7:0] & 8'h05;
                `PMW_ADDR_LXTAL:  low_crystal_ctrl_reg  <= pwdata[7:0] & 8'h01;
                `PMW_ADDR_WDT:    wdt_ctrl_reg          <= pwdata[7:0];
                `PMW_ADDR_PAWAKE: porta_wake_enable     <= pwdata[PORT_WIDTH-1:0];
                default:          ;
            endcase
        end
    end

    // Stable flags: drop on enable or frequency change, rise on ready
    // The enabling write wins over ready in the same cycle, so the drop is always seen
    wire lxtWr = apbWr && !halted && (paddr == `PMW_ADDR_LXTAL);
    wire hrcWr = apbWr && !halted && (paddr == `PMW_ADDR_HRC);
    wire hxtWr = apbWr && !halted && (paddr == `PMW_ADDR_HXTAL);
    always @(posedge clk) begin
        if (reset) begin
            low_crystal_stable_flag  <= 1'b0;
            high_rc_stable_flag      <= 1'b0;
            high_crystal_stable_flag <= 1'b0;
        end else begin
            if (lxtWr && pwdata[`PMW_EN_BIT])
                low_crystal_stable_flag <= 1'b0;
            else
                low_crystal_stable_flag <= lxtRdy;
            if (hrcWr)
                high_rc_stable_flag <= 1'b0;
            else
                high_rc_stable_flag <= hrcRdy;
            if (hxtWr && pwdata[`PMW_EN_BIT])
                high_crystal_stable_flag <= 1'b0;
            else
                high_crystal_stable_flag <= hxtRdy;
        end
    end

    // Status flags; a halt in the same cycle as a clear keeps the flag set
    // Timeout is cleared only by halt entry and reset; an overflow sets it while wdtRun is high, except in a halt entry cycle
    always @(posedge clk) begin
        if (reset) begin
            power_down_flag  <= 1'b0;
            wdt_timeout_flag <= 1'b0;
        end else begin
            if (haltExec && !halted) begin
                power_down_flag  <= 1'b1;
                wdt_timeout_flag <= 1'b0;
            end else begin
                if (clearWdtExec)
                    power_down_flag <= 1'b0;
                if (wdtOvf && wdtRun)
                    wdt_timeout_flag <= 1'b1;
            end
        end
    end

    // Mode machine: halt, wake, and fast/slow switching
    // Codes FAST and SLOW run the CPU, SLEEP and the idle codes stop it,
    // and WAKE holds it until the running source is stable again
    always @(posedge clk) begin
        if (reset) begin
            state         <= `PMW_MODE_FAST;
            slowActive    <= 1'b0;
            irqArmed      <= {IRQ_WIDTH{1'b0}};
            pcSpReset     <= 1'b0;
            irqServiceNow <= 1'b0;
            wdtClear      <= 1'b0;
        end else begin
            pcSpReset     <= 1'b0;
            irqServiceNow <= 1'b0;
            wdtClear      <= clearWdtExec;
            case (state)
                `PMW_MODE_FAST, `PMW_MODE_SLOW: begin
                    // Switch only once the target source is stable
                    if (cks == `PMW_CKS_SLOW && slowRdy)
                        slowActive <= 1'b1;
                    else if (cks != `PMW_CKS_SLOW && fastRdy)
                        slowActive <= 1'b0;
                    if (haltExec) begin
                        // Requests already pending at halt may not wake the device
                        irqArmed <= ~irqFlag;
                        wdtClear <= 1'b1;
                        // Fast idle enable is the upper bit of the decode
                        case ({fhIdle, fsIdle})
                            2'b00:   state <= `PMW_MODE_SLEEP;
                            2'b01:   state <= `PMW_MODE_IDLE_SLOW_ONLY;
                            2'b11:   state <= `PMW_MODE_IDLE_BOTH_CLOCKS;
                            default: state <= `PMW_MODE_IDLE_FAST_ONLY;
                        endcase
                    end else begin
                        state <= slowActive ? `PMW_MODE_SLOW : `PMW_MODE_FAST;
                    end
                end
                `PMW_MODE_SLEEP, `PMW_MODE_IDLE_SLOW_ONLY, `PMW_MODE_IDLE_BOTH_CLOCKS, `PMW_MODE_IDLE_FAST_ONLY: begin
                    // A bit seen set while halted is disarmed, so it wakes only once
                    irqArmed <= irqArmed & ~irqFlag;
                    if (anyWake) begin
                        state     <= `PMW_MODE_WAKE;
                        pcSpReset <= wdtOvf & wdtRun & ~extResetReq;
                        irqServiceNow <= (|(irqFresh & irqEnable)) & ~stackFull;
                    end
                end
                `PMW_MODE_WAKE: begin
                    // Hold CPU until the running source reports stable
                    // No timeout here: a source that never settles keeps the CPU held
                    if (slowActive ? slowRdy : fastRdy)
                        state <= slowActive ? `PMW_MODE_SLOW : `PMW_MODE_FAST;
                end
                // Unused codes fall back to fast mode rather than lock the CPU
                default: state <= `PMW_MODE_FAST;
            endcase
        end
    end

    // Oscillator enables and clock gates per mode
    // Registered so gates change only on an edge; they lag the state by a cycle
    always @(posedge clk) begin
        if (reset) begin
            highRcOn        <= 1'b1;
            highCrystalOn   <= 1'b0;
            lowCrystalOn    <= 1'b0;
            lowRcOn         <= 1'b1;
            fastClockEnable <= 1'b1;
            slowClockEnable <= 1'b1;
            sysClockIsSlow  <= 1'b0;
            fastDivideSel   <= 3'h0;
            slowFromCrystal <= 1'b0;
            cpuRun          <= 1'b1;
            wdtRun          <= 1'b0;
            powerMode       <= `PMW_MODE_FAST;
        end else begin
            fastClockEnable <= !halted || fhIdle;
            slowClockEnable <= !halted || fsIdle;
            highRcOn      <= high_rc_ctrl_reg[`PMW_EN_BIT] && (!halted || fhIdle);
            highCrystalOn <= high_crystal_ctrl_reg[`PMW_EN_BIT] && (!halted || fhIdle);
            lowCrystalOn  <= low_crystal_ctrl_reg[`PMW_EN_BIT] && (!halted || fsIdle);
            lowRcOn       <= wdtEnabled || !halted || fsIdle;
            sysClockIsSlow  <= slowActive;
            // Keep the last divide while a slow switch waits, so 111 never reaches the divider
            if (!slowActive && cks != `PMW_CKS_SLOW)
                fastDivideSel <= cks;
            // While the system clock is slow, a new slow source takes over only once it is stable; in fast mode it takes over at once
            if (!slowActive || slowRdy)
                slowFromCrystal <= slow_source_select;
            // The CPU runs only in a run mode; WAKE still holds it
            cpuRun    <= runMode(state);
            wdtRun    <= wdtEnabled;
            powerMode <= state;
        end
    end

endmodule // pmw_power_mode_wake_controller
`default_nettype wire

// ---- dv/pmw_power_mode_wake_controller_sva.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "pmw_defs.vh"
module pmw_power_mode_wake_controller_sva (
    input wire logic        clk,
    input wire logic        reset,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic        haltExec,
    input wire logic        extResetReq,
    input wire logic        lowRcOn,
    input wire logic        fastClockEnable,
    input wire logic        slowClockEnable,
    input wire logic        sysClockIsSlow,
    input wire logic        cpuRun,
    input wire logic        wdtClear,
    input wire logic        wdtRun,
    input wire logic        pcSpReset,
    input wire logic [2:0]  powerMode
);
    logic [1:0] idleBits;
    logic [2:0] expMode;
    logic       halted;
    default clocking @(posedge clk); endclocking
    default disable iff (reset);
    // Shadow of the idle enables; writes while halted are dropped, so gate on cpuRun
    always_ff @(posedge clk) begin
        if (reset)
            idleBits <= 2'h0;
        else if (psel && penable && pwrite && paddr == `PMW_ADDR_SYSCLK && cpuRun)
            idleBits <= pwdata[1:0];
    end
    // Mode that a halt must pick from the two enables
    assign expMode = (idleBits == 2'h0) ? `PMW_MODE_SLEEP :
                     (idleBits == 2'h1) ? `PMW_MODE_IDLE_SLOW_ONLY :
                     (idleBits == 2'h3) ? `PMW_MODE_IDLE_BOTH_CLOCKS : `PMW_MODE_IDLE_FAST_ONLY;
    assign halted = powerMode >= `PMW_MODE_SLEEP && powerMode <= `PMW_MODE_IDLE_FAST_ONLY;
    property p_halt_clear; haltExec && cpuRun |=> wdtClear; endproperty
    a_halt_clear: assert property (p_halt_clear) else $error("no watchdog clear on halt");
    property p_halt_mode; haltExec && cpuRun |-> ##[1:2] powerMode == expMode; endproperty
    a_halt_mode: assert property (p_halt_mode) else $error("halt mode wrong");
    property p_sleep_clk;
        (powerMode == `PMW_MODE_SLEEP) [*2] |-> !fastClockEnable && !slowClockEnable && !cpuRun;
    endproperty
    a_sleep_clk: assert property (p_sleep_clk) else $error("clock runs in sleep");
    property p_idle_slow_only_clk; (powerMode == `PMW_MODE_IDLE_SLOW_ONLY) [*2] |-> !fastClockEnable && slowClockEnable; endproperty
    a_idle_slow_only_clk: assert property (p_idle_slow_only_clk) else $error("slow-only idle clocks wrong");
    property p_idle_both_clocks_clk; (powerMode == `PMW_MODE_IDLE_BOTH_CLOCKS) [*2] |-> fastClockEnable && slowClockEnable; endproperty
    a_idle_both_clocks_clk: assert property (p_idle_both_clocks_clk) else $error("both-clock idle clocks wrong");
    property p_idle_fast_only_clk; (powerMode == `PMW_MODE_IDLE_FAST_ONLY) [*2] |-> fastClockEnable && !slowClockEnable; endproperty
    a_idle_fast_only_clk: assert property (p_idle_fast_only_clk) else $error("fast-only idle clocks wrong");
    property p_wake_ext; halted && extResetReq |-> ##[1:12] cpuRun; endproperty
    a_wake_ext: assert property (p_wake_ext) else $error("no wake on external reset");
    property p_pcsp; pcSpReset |-> $past(halted); endproperty
    a_pcsp: assert property (p_pcsp) else $error("pc and stack reset outside halt");
    property p_lowrc; wdtRun |-> lowRcOn; endproperty
    a_lowrc: assert property (p_lowrc) else $error("low rc off while watchdog runs");
    // Main scenarios reached
    c_halt: cover property (haltExec && cpuRun);
    c_wake: cover property (halted ##1 !halted);
    c_slow: cover property ($rose(sysClockIsSlow));
endmodule // pmw_power_mode_wake_controller_sva
`default_nettype wire

// ---- dv/pmw_power_mode_wake_controller_tb_top.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "pmw_defs.vh"
module pmw_power_mode_wake_controller_tb_top;
    logic        clk, reset, psel, penable, pwrite, haltExec, clearWdtExec, extResetReq, stackFull;
    logic        highRcReady, highCrystalReady, lowCrystalReady, lowRcReady, wdtOverflow;
    logic        pready, pslverr, highRcOn, highCrystalOn, lowCrystalOn, lowRcOn, cpuRun;
    logic        fastClockEnable, slowClockEnable, sysClockIsSlow, slowFromCrystal;
    logic        wdtClear, wdtRun, pcSpReset, irqServiceNow;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [7:0]  irqFlag, irqEnable, portAPins;
    logic [2:0]  fastDivideSel, powerMode;
    logic [2:0]  expm [5] = '{`PMW_MODE_SLEEP, `PMW_MODE_IDLE_SLOW_ONLY, `PMW_MODE_IDLE_FAST_ONLY,
                              `PMW_MODE_IDLE_BOTH_CLOCKS, `PMW_MODE_SLEEP};
    int          fails, checked, irqSeen, pcSeen, i;
    pmw_power_mode_wake_controller dut (.clk, .reset, .psel, .penable, .pwrite, .paddr, .pwdata,
        .pready, .prdata, .pslverr, .haltExec, .clearWdtExec, .extResetReq, .irqFlag, .irqEnable,
        .stackFull, .portAPins, .highRcReady, .highCrystalReady, .lowCrystalReady, .lowRcReady,
        .wdtOverflow, .highRcOn, .highCrystalOn, .lowCrystalOn, .lowRcOn, .fastClockEnable,
        .slowClockEnable, .sysClockIsSlow, .fastDivideSel, .slowFromCrystal, .cpuRun, .wdtClear,
        .wdtRun, .pcSpReset, .irqServiceNow, .powerMode);
    initial begin
        clk = 1'h0;
        forever #4 clk = ~clk;
    end
    // Pulses last one cycle, so count them where they appear
    always @(posedge clk) begin
        if (irqServiceNow === 1'h1) irqSeen++;
        if (pcSpReset === 1'h1) pcSeen++;
    end
    task wrap_up;
        $display("checks %0d mismatches %0d", checked, fails);
        if (fails == 0 && checked > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    task check(input string nm, input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            fails++;
            $display("wrong value %s expected %h seen %h", nm, exp, got);
        end
    endtask
    // One APB transfer; held until pready is seen high at an edge
    task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        psel <= 1'h1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'h1;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'h1 && n < 50);
        rd = prdata;
        check("slave error", pslverr, 32'h0);
        psel <= 1'h0;
        penable <= 1'h0;
        if (n >= 50) begin fails++; wrap_up(); end
        @(posedge clk);
    endtask
    // Read until the expected word shows or the tries run out
    task rchk(input string nm, input logic [11:0] a, input logic [31:0] e, input int tries);
        for (int t = 0; t < tries; t++) begin
            apb(1'h0, a, 32'h0);
            if (rd === e) break;
        end
        check(nm, rd, e);
    endtask
    task waitfor(input int sel);
        int n;
        n = 0;
        while ((sel == 0 ? cpuRun : sel == 1 ? sysClockIsSlow : !sysClockIsSlow) !== 1'h1
               && n < 100) begin
            @(posedge clk);
            n++;
        end
        if (n >= 100) begin fails++; wrap_up(); end
    endtask
    task halt;
        haltExec <= 1'h1;
        @(posedge clk);
        haltExec <= 1'h0;
        repeat (3) @(posedge clk);
    endtask
    initial begin
        {reset, psel, penable, pwrite, haltExec, clearWdtExec, extResetReq} = 7'h40;
        {stackFull, highCrystalReady, lowCrystalReady, lowRcReady, wdtOverflow} = 5'h0;
        {paddr, pwdata, irqFlag} = 52'h0;
        highRcReady = 1'h1;
        irqEnable = 8'hff;
        portAPins = 8'hff;
        repeat (3) @(posedge clk);
        reset <= 1'h0;
        repeat (4) @(posedge clk);
        // Crystal control: flag stays low until the oscillator reports ready
        rchk("crystal reset", `PMW_ADDR_LXTAL, 32'h0, 1);
        rchk("unmapped", 12'h020, 32'h0, 1);
        apb(1'h1, `PMW_ADDR_LXTAL, 32'hff);
        rchk("crystal unstable", `PMW_ADDR_LXTAL, 32'h1, 1);
        check("crystal on", lowCrystalOn, 1'h1);
        check("high crystal off", highCrystalOn, 1'h0);
        lowCrystalReady <= 1'h1;
        rchk("crystal stable", `PMW_ADDR_LXTAL, 32'h3, 20);
        $display("test crystal control done");
        // Slow switch waits for its source; fast return waits for the fast source
        apb(1'h1, `PMW_ADDR_SYSCLK, 32'he0);
        repeat (10) @(posedge clk);
        check("slow too early", sysClockIsSlow, 1'h0);
        check("divide kept", fastDivideSel, 3'h0);
        lowRcReady <= 1'h1;
        waitfor(1);
        check("slow from rc", slowFromCrystal, 1'h0);
        highRcReady <= 1'h0;
        repeat (3) @(posedge clk);
        apb(1'h1, `PMW_ADDR_SYSCLK, 32'h0);
        repeat (10) @(posedge clk);
        check("fast too early", sysClockIsSlow, 1'h1);
        highRcReady <= 1'h1;
        for (i = 0; i < 7; i++) begin
            apb(1'h1, `PMW_ADDR_SYSCLK, {24'h0, i[2:0], 5'h0});
            waitfor(2);
            @(posedge clk);
            check("divide", fastDivideSel, i[2:0]);
        end
        apb(1'h1, `PMW_ADDR_SYSCLK, 32'he4);
        waitfor(1);
        check("slow from crystal", slowFromCrystal, 1'h1);
        apb(1'h1, `PMW_ADDR_SYSCLK, 32'h0);
        waitfor(2);
        $display("test clock switch done");
        // Each halt mode, woken by port edge, interrupt, external reset, watchdog
        apb(1'h1, `PMW_ADDR_PAWAKE, 32'h1);
        for (i = 0; i < 5; i++) begin
            apb(1'h1, `PMW_ADDR_SYSCLK, {30'h0, i[1:0]});
            stackFull <= (i == 4);
            if (i == 1 || i == 4) irqFlag <= 8'h02;
            halt();
            check("mode", powerMode, expm[i]);
            check("cpu held", cpuRun, 1'h0);
            check("watchdog runs", wdtRun, 1'h1);
            check("fast osc", highRcOn, i == 2 || i == 3);
            check("slow osc", lowCrystalOn, i == 1 || i == 3);
            rchk("status halted", `PMW_ADDR_STATUS, 32'h1, 1);
            case (i)
                0: portAPins <= 8'hfe;
                2: extResetReq <= 1'h1;
                3: wdtOverflow <= 1'h1;
                default: begin
                    repeat (10) @(posedge clk);
                    check("stale irq", cpuRun, 1'h0);
                    irqFlag <= 8'h06;
                end
            endcase
            waitfor(0);
            {portAPins, irqFlag, extResetReq, wdtOverflow} <= 18'h3fc00;
            rchk("status woken", `PMW_ADDR_STATUS, (i == 3) ? 32'h3 : 32'h1, 1);
        end
        check("irq service", irqSeen, 32'h1);
        check("pc sp reset", pcSeen, 32'h1);
        clearWdtExec <= 1'h1;
        @(posedge clk);
        clearWdtExec <= 1'h0;
        rchk("pd cleared", `PMW_ADDR_STATUS, 32'h0, 3);
        $display("test halt and wake done");
        wrap_up();
    end
endmodule // pmw_power_mode_wake_controller_tb_top
bind pmw_power_mode_wake_controller pmw_power_mode_wake_controller_sva u_sva (.clk, .reset,
    .psel, .penable, .pwrite, .paddr, .pwdata, .haltExec, .extResetReq, .lowRcOn,
    .fastClockEnable, .slowClockEnable, .sysClockIsSlow, .cpuRun, .wdtClear, .wdtRun,
    .pcSpReset, .powerMode);
`default_nettype wire
